// File: csd_defines.svh
// Purpose: Constants for the card space decoder
// Assumes: Attribute byte addresses on the host address pins
// Notes:   Offsets are byte addresses inside attribute space
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH
`define CSD_ADDR_W        11
`define CSD_CFG_BASE      11'h200
`define CSD_OFS_OPTION    3'h0
`define CSD_OFS_STATUS    3'h2
`define CSD_OFS_PINREP    3'h4
`define CSD_OFS_SOCKET    3'h6
`define CSD_RST_OPTION    8'h00
`define CSD_RST_STATUS    8'h00
`define CSD_RST_PINREP    8'h00
`define CSD_RST_SOCKET    8'h00
`define CSD_OPT_SOFT_RST  7
`define CSD_STAT_WMASK    8'h6c
`define CSD_STAT_INT      1
`define CSD_PIN_RD_ONES   8'h0c
`define CSD_PIN_CRDY      5
`define CSD_PIN_CWP       4
`define CSD_PIN_MRDY      1
`define CSD_PIN_MWP       0
`define CSD_SOCK_WMASK    8'h1f
`define CSD_CIS_DEPTH     256
`define CSD_CIS_AW        8
`endif

// File: csd_pkg.sv
// Purpose: Types for the card space decoder
// Assumes: Nothing
// Notes:   Space codes name the selected region
package csd_pkg;
  typedef enum logic [2:0] {
    CSD_SP_STANDBY,
    CSD_SP_CONFIG,
    CSD_SP_CIS,
    CSD_SP_COMMON,
    CSD_SP_INVALID,
    CSD_SP_NONE
  } csd_space_t;
  typedef enum logic [1:0] {
    CSD_LANE_NONE,
    CSD_LANE_LOW,
    CSD_LANE_HIGH,
    CSD_LANE_WORD
  } csd_lane_t;
  typedef enum logic [1:0] {
    CSD_ST_IDLE,
    CSD_ST_ACTIVE,
    CSD_ST_DONE
  } csd_state_t;
endpackage : csd_pkg

// File: csd_space_decode.sv
// Purpose: Combinational space and lane decode of the memory-mode strobes
// Assumes: Strobes sampled synchronously
// Notes:   Pure decode, no state
`timescale 1ns/10ps
`include "csd_defines.svh"
module csd_space_decode (
  // Host strobes
  input  wire logic                   i_low_byte_chip_select_n,
  input  wire logic                   i_high_byte_chip_select_n,
  input  wire logic                   i_attr_select_n,
  input  wire logic                   i_read_n,
  input  wire logic                   i_write_n,
  input  wire logic [`CSD_ADDR_W-1:0] i_addr,
  // Decode results
  output csd_pkg::csd_space_t         o_space,
  output csd_pkg::csd_lane_t          o_lane
);
  import csd_pkg::*;
  logic addr_bit_ten;
  logic addr_bit_nine;
  logic addr_bit_zero;
  logic strobe;
  assign addr_bit_ten  = i_addr[10];
  assign addr_bit_nine = i_addr[9];
  assign addr_bit_zero = i_addr[0];
  assign strobe        = ~i_read_n ^ ~i_write_n;

  always_comb begin
    o_space = CSD_SP_NONE;
    o_lane  = CSD_LANE_NONE;
    if (i_low_byte_chip_select_n && i_high_byte_chip_select_n) begin
      o_space = CSD_SP_STANDBY;
    end else if (!strobe) begin
      o_space = CSD_SP_NONE;
    end else if (i_attr_select_n) begin
      o_space = CSD_SP_COMMON;
      if (!i_low_byte_chip_select_n && i_high_byte_chip_select_n) begin
        o_lane = CSD_LANE_LOW;
      end else if (i_low_byte_chip_select_n) begin
        o_lane = CSD_LANE_HIGH;
      end else if (!addr_bit_zero) begin
        o_lane = CSD_LANE_WORD;
      end else begin
        o_space = CSD_SP_NONE;
      end
    end else if (i_low_byte_chip_select_n || addr_bit_zero) begin
      o_space = CSD_SP_INVALID;
      o_lane  = i_low_byte_chip_select_n ? CSD_LANE_HIGH : CSD_LANE_LOW;
    end else if (!addr_bit_ten && addr_bit_nine) begin
      o_space = CSD_SP_CONFIG;
      o_lane  = CSD_LANE_LOW;
    end else if (!addr_bit_ten && !addr_bit_nine) begin
      o_space = i_read_n ? CSD_SP_INVALID : CSD_SP_CIS;
      o_lane  = CSD_LANE_LOW;
    end else begin
      o_space = CSD_SP_INVALID;
      o_lane  = CSD_LANE_LOW;
    end
  end
endmodule : csd_space_decode

// File: csd_cis_rom.sv
// Purpose: Card information structure storage, read only from the host side
// Assumes: Loaded through a private load port
// Notes:   Content is held in a register array
`timescale 1ns/10ps
`include "csd_defines.svh"
module csd_cis_rom (
  // Clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  // Load port
  input  wire logic                  i_load,
  input  wire logic [`CSD_CIS_AW-1:0] i_load_addr,
  input  wire logic [7:0]            i_load_data,
  // Read port
  input  wire logic [`CSD_CIS_AW-1:0] i_rd_addr,
  output logic      [7:0]            o_rd_data
);
  logic [7:0] mem [`CSD_CIS_DEPTH];

  always_ff @(posedge i_sys_clk) begin
    if (i_load) begin
      mem[i_load_addr] <= i_load_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= mem[i_rd_addr];
    end
  end
endmodule : csd_cis_rom

// File: csd_card_space_decoder.sv
// Purpose: Memory-mode host port decoder with configuration registers
// Assumes: Host strobes synchronous to i_sys_clk
// Notes:   Writes commit on the first cycle of a write strobe
`timescale 1ns/10ps
`include "csd_defines.svh"
module csd_card_space_decoder (
  // Clock and reset
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_n,
  // Host strobes
  input  wire logic                   i_low_byte_chip_select_n,
  input  wire logic                   i_high_byte_chip_select_n,
  input  wire logic                   i_attr_select_n,
  input  wire logic                   i_read_n,
  input  wire logic                   i_write_n,
  input  wire logic [`CSD_ADDR_W-1:0] i_addr,
  // Data lanes
  input  wire logic [15:0]            i_data,
  output logic      [15:0]            o_data,
  output logic                        o_data_lo_oe_n,
  output logic                        o_data_hi_oe_n,
  // Common memory side
  output logic                        o_common_rd,
  output logic                        o_common_wr,
  output logic      [`CSD_ADDR_W-1:0] o_common_addr,
  output logic      [1:0]             o_common_be,
  output logic      [15:0]            o_common_wdata,
  input  wire logic [15:0]            i_common_rdata,
  // Card side status and control
  input  wire logic                   i_ready,
  input  wire logic                   i_int_req,
  input  wire logic                   i_cis_load,
  input  wire logic [`CSD_CIS_AW-1:0] i_cis_load_addr,
  input  wire logic [7:0]             i_cis_load_data,
  output logic      [7:0]             o_configuration_option,
  output logic                        o_soft_reset,
  output logic                        o_power_down,
  output logic                        o_invalid_access
);
  import csd_pkg::*;

  csd_space_t space;
  csd_lane_t  lane;
  csd_state_t state;
  csd_state_t next_state;
  logic [7:0] card_config_and_status;
  logic [7:0] pin_replacement;
  logic [7:0] socket_and_copy;
  logic       ready_q;
  logic [7:0] cis_data;
  logic [7:0] reg_rdata;
  logic       start;
  logic       is_write;
  logic       cfg_wr;
  logic [2:0] cfg_ofs;
  logic       cfg_hit;
  logic       attr_rd;
  logic       attr_cfg_rd;
  logic       ready_seen;
  logic       ready_chg;
  logic [1:0] commit_cnt;

  function automatic logic [2:0] csd_cfg_offset(input logic [`CSD_ADDR_W-1:0] a);
    csd_cfg_offset = a[2:0];
  endfunction : csd_cfg_offset

  csd_space_decode u_decode (
    .i_low_byte_chip_select_n  (i_low_byte_chip_select_n),
    .i_high_byte_chip_select_n (i_high_byte_chip_select_n),
    .i_attr_select_n           (i_attr_select_n),
    .i_read_n                  (i_read_n),
    .i_write_n                 (i_write_n),
    .i_addr                    (i_addr),
    .o_space                   (space),
    .o_lane                    (lane)
  );

  csd_cis_rom u_cis (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_load      (i_cis_load),
    .i_load_addr (i_cis_load_addr),
    .i_load_data (i_cis_load_data),
    .i_rd_addr   (i_addr[`CSD_CIS_AW:1]),
    .o_rd_data   (cis_data)
  );

  // Cycle delimiting: one commit per strobe assertion
  always_comb begin
    next_state = state;
    case (state)
      CSD_ST_IDLE: begin
        if (space != CSD_SP_STANDBY && space != CSD_SP_NONE) begin
          next_state = CSD_ST_ACTIVE;
        end
      end
      CSD_ST_ACTIVE: begin
        next_state = CSD_ST_DONE;
        if (space == CSD_SP_STANDBY || space == CSD_SP_NONE) begin
          next_state = CSD_ST_IDLE;
        end
      end
      default: begin
        if (space == CSD_SP_STANDBY || space == CSD_SP_NONE) begin
          next_state = CSD_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= CSD_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign start    = (state == CSD_ST_IDLE) && (space != CSD_SP_STANDBY) && (space != CSD_SP_NONE);
  assign is_write = ~i_write_n;
  assign cfg_ofs  = csd_cfg_offset(i_addr);
  assign cfg_hit  = (i_addr[8:3] == 6'h00) && !cfg_ofs[0];
  assign cfg_wr   = start && is_write && (space == CSD_SP_CONFIG) && cfg_hit;
  assign attr_rd     = !i_attr_select_n && !i_low_byte_chip_select_n && !i_read_n && i_write_n;
  assign attr_cfg_rd = attr_rd && ((i_addr & 11'h7f8) == `CSD_CFG_BASE);

  // Configuration option register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_configuration_option <= `CSD_RST_OPTION;
    end else if (cfg_wr && cfg_ofs == `CSD_OFS_OPTION) begin
      o_configuration_option <= i_data[7:0];
    end
  end
  assign o_soft_reset = o_configuration_option[`CSD_OPT_SOFT_RST];

  // Card configuration and status register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      card_config_and_status <= `CSD_RST_STATUS;
    end else if (cfg_wr && cfg_ofs == `CSD_OFS_STATUS) begin
      card_config_and_status <= i_data[7:0] & `CSD_STAT_WMASK;
    end
  end
  assign o_power_down = card_config_and_status[2];

  // Ready change detector, armed one cycle after reset so release gives no false edge
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ready_q    <= 1'b0;
      ready_seen <= 1'b0;
    end else begin
      ready_q    <= i_ready;
      ready_seen <= 1'b1;
    end
  end
  assign ready_chg = ready_seen && (ready_q ^ i_ready);

  // Starts seen since the host last delimited a cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      commit_cnt <= 2'h0;
    end else if (space == CSD_SP_STANDBY || space == CSD_SP_NONE) begin
      commit_cnt <= 2'h0;
    end else if (start && commit_cnt != 2'h3) begin
      commit_cnt <= commit_cnt + 2'h1;
    end
  end

  // Pin replacement register: hardware set wins over host clear
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_replacement <= `CSD_RST_PINREP;
    end else begin
      if (cfg_wr && cfg_ofs == `CSD_OFS_PINREP && i_data[`CSD_PIN_MRDY]) begin
        pin_replacement[`CSD_PIN_CRDY] <= i_data[`CSD_PIN_CRDY] | ready_chg;
      end else if (ready_chg) begin
        pin_replacement[`CSD_PIN_CRDY] <= 1'b1;
      end
      if (cfg_wr && cfg_ofs == `CSD_OFS_PINREP && i_data[`CSD_PIN_MWP]) begin
        pin_replacement[`CSD_PIN_CWP] <= i_data[`CSD_PIN_CWP];
      end
    end
  end

  // Socket and copy register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      socket_and_copy <= `CSD_RST_SOCKET;
    end else if (cfg_wr && cfg_ofs == `CSD_OFS_SOCKET) begin
      socket_and_copy <= i_data[7:0] & `CSD_SOCK_WMASK;
    end
  end

  // Register read mux
  always_comb begin
    reg_rdata = 8'h00;
    if (!cfg_hit) begin
      reg_rdata = 8'h00;
    end else if (cfg_ofs == `CSD_OFS_OPTION) begin
      reg_rdata = o_configuration_option;
    end else if (cfg_ofs == `CSD_OFS_STATUS) begin
      reg_rdata = card_config_and_status | {1'b0, 5'h00, i_int_req, 1'b0}
                  | {pin_replacement[`CSD_PIN_CRDY] | pin_replacement[`CSD_PIN_CWP], 7'h00};
    end else if (cfg_ofs == `CSD_OFS_PINREP) begin
      reg_rdata = (pin_replacement & 8'h30) | `CSD_PIN_RD_ONES | {6'h00, i_ready, 1'b0};
    end else begin
      reg_rdata = socket_and_copy;
    end
  end

  // Common memory strobes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_common_rd    <= 1'b0;
      o_common_wr    <= 1'b0;
      o_common_addr  <= '0;
      o_common_be    <= 2'b00;
      o_common_wdata <= 16'h0000;
    end else begin
      o_common_rd    <= start && !is_write && space == CSD_SP_COMMON;
      o_common_wr    <= start && is_write && space == CSD_SP_COMMON;
      o_common_addr  <= i_addr;
      o_common_be    <= (lane == CSD_LANE_WORD) ? 2'b11 : (lane == CSD_LANE_HIGH) ? 2'b10 : 2'b01;
      o_common_wdata <= i_data;
    end
  end

  // Read data and lane enables
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data         <= 16'h0000;
      o_data_lo_oe_n <= 1'b1;
      o_data_hi_oe_n <= 1'b1;
    end else if (space == CSD_SP_STANDBY || space == CSD_SP_NONE || is_write) begin
      o_data_lo_oe_n <= 1'b1;
      o_data_hi_oe_n <= 1'b1;
    end else begin
      o_data_lo_oe_n <= !(lane == CSD_LANE_LOW || lane == CSD_LANE_WORD);
      o_data_hi_oe_n <= !(lane == CSD_LANE_HIGH || lane == CSD_LANE_WORD);
      if (space == CSD_SP_COMMON) begin
        o_data <= i_common_rdata;
      end else if (space == CSD_SP_CONFIG) begin
        o_data <= {8'h00, reg_rdata};
      end else if (space == CSD_SP_CIS) begin
        o_data <= {8'h00, cis_data};
      end else begin
        o_data <= 16'h0000;
      end
    end
  end

  // Invalid access flag, one pulse per cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_invalid_access <= 1'b0;
    end else begin
      o_invalid_access <= start && space == CSD_SP_INVALID;
    end
  end

  standby_float_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_low_byte_chip_select_n && i_high_byte_chip_select_n) |=> (o_data_lo_oe_n && o_data_hi_oe_n))
    else $error("lanes driven in standby");
  attr_upper_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!i_attr_select_n && !i_low_byte_chip_select_n && !i_read_n && i_write_n && !i_addr[0]) |=> o_data_hi_oe_n)
    else $error("upper lane driven on attribute read");
  invalid_noreg_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (start && space == CSD_SP_INVALID) |=> $stable(o_configuration_option) && $stable(socket_and_copy))
    else $error("invalid access changed a register");
  option_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    cfg_wr && cfg_ofs == `CSD_OFS_OPTION |=> o_configuration_option == $past(i_data[7:0]))
    else $error("option register not written");
  socket_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    cfg_wr && cfg_ofs == `CSD_OFS_SOCKET |=> socket_and_copy == ($past(i_data[7:0]) & 8'h1f))
    else $error("socket register not written");
  common_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (start && i_attr_select_n && !i_low_byte_chip_select_n && i_high_byte_chip_select_n) |=> o_common_be == 2'b01)
    else $error("low byte lane wrong");
  common_word_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (start && i_attr_select_n && !i_low_byte_chip_select_n && !i_high_byte_chip_select_n) |=> o_common_be == 2'b11)
    else $error("word lanes wrong");
  cis_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (start && !i_attr_select_n && !i_write_n && !i_addr[10] && !i_addr[9]) |=> o_invalid_access)
    else $error("info structure write not flagged");
  odd_attr_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (start && !i_attr_select_n && i_addr[0]) |=> o_invalid_access)
    else $error("odd attribute access not flagged");
  one_commit_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_common_wr |=> !o_common_wr)
    else $error("two commits in one cycle");

  // Register read, ready latch and word write checks
  option_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    attr_cfg_rd && i_addr[2:0] == `CSD_OFS_OPTION
    |=> !o_data_lo_oe_n && o_data[7:0] == o_configuration_option)
    else $error("option register read wrong");
  status_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    attr_cfg_rd && i_addr[2:0] == `CSD_OFS_STATUS
    |=> o_data[1] == $past(i_int_req) && !o_data[0])
    else $error("status register read wrong");
  pin_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    attr_cfg_rd && i_addr[2:0] == `CSD_OFS_PINREP
    |=> o_data[3:2] == 2'b11 && o_data[1] == $past(i_ready))
    else $error("pin replacement read wrong");
  socket_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    attr_cfg_rd && i_addr[2:0] == `CSD_OFS_SOCKET
    |=> o_data[7:0] == socket_and_copy)
    else $error("socket register read wrong");
  ready_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ready_chg
    |=> pin_replacement[`CSD_PIN_CRDY])
    else $error("ready change not latched");
  word_cfg_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    start && !i_attr_select_n && !i_low_byte_chip_select_n && !i_high_byte_chip_select_n
    && !i_write_n && i_addr == `CSD_CFG_BASE
    |=> o_configuration_option == $past(i_data[7:0]))
    else $error("word register write lost");

  // Lane checks
  cis_lane_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    attr_rd && !i_addr[10] && !i_addr[9] && !i_addr[0]
    |=> !o_data_lo_oe_n && o_data_hi_oe_n)
    else $error("info structure lanes wrong");
  write_float_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_write_n && i_read_n
    |=> o_data_lo_oe_n && o_data_hi_oe_n)
    else $error("lanes driven on write");
  word_lanes_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    start && i_attr_select_n && !i_low_byte_chip_select_n && !i_high_byte_chip_select_n && !i_read_n
    |=> !o_data_lo_oe_n && !o_data_hi_oe_n)
    else $error("word read lanes wrong");

  // Common memory checks
  common_high_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    start && i_attr_select_n && i_low_byte_chip_select_n
    |=> o_common_be == 2'b10)
    else $error("high byte lane wrong");
  attr_no_common_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_attr_select_n
    |=> !o_common_rd && !o_common_wr)
    else $error("attribute access reached common memory");

  // Invalid access and delimiting checks
  high_only_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    start && !i_attr_select_n && i_low_byte_chip_select_n
    |=> o_invalid_access)
    else $error("high only attribute access not flagged");
  one_start_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    commit_cnt < 2'h2)
    else $error("held strobe started twice");
endmodule : csd_card_space_decoder

// File: csd_host_model.sv
// Purpose: Host socket model driving the memory-mode strobes of the card
// Assumes: The bench calls cyc from one process only
// Notes:   Inputs change on the falling edge; data is inverted once released
`timescale 1ns/10ps
`include "csd_defines.svh"
module csd_host_model (
  // Clock
  input  wire logic                   i_sys_clk,
  // Strobes to the card
  output logic                        o_low_byte_chip_select_n,
  output logic                        o_high_byte_chip_select_n,
  output logic                        o_attr_select_n,
  output logic                        o_read_n,
  output logic                        o_write_n,
  output logic      [`CSD_ADDR_W-1:0] o_addr,
  output logic      [15:0]            o_data,
  // Card answer
  input  wire logic [15:0]            i_data,
  input  wire logic                   i_data_lo_oe_n,
  input  wire logic                   i_data_hi_oe_n
);
  initial begin
    o_low_byte_chip_select_n  = 1'b1;
    o_high_byte_chip_select_n = 1'b1;
    o_attr_select_n           = 1'b1;
    o_read_n                  = 1'b1;
    o_write_n                 = 1'b1;
    o_addr                    = '0;
    o_data                    = 16'h0000;
  end
  // One access: strobe held four cycles, answer taken in the last one
  task automatic cyc(input logic a, l, h, w, input logic [`CSD_ADDR_W-1:0] ad,
                     input logic [15:0] wd, output logic [15:0] rd, output logic ol, oh);
    @(negedge i_sys_clk);
    o_attr_select_n           = a;
    o_low_byte_chip_select_n  = l;
    o_high_byte_chip_select_n = h;
    o_addr                    = ad;
    o_data                    = w ? wd : ~o_data;
    o_read_n                  = w;
    o_write_n                 = ~w;
    repeat (3) @(negedge i_sys_clk);
    rd = i_data;
    ol = i_data_lo_oe_n;
    oh = i_data_hi_oe_n;
    @(negedge i_sys_clk);
    // Both chip selects and both strobes dropped, attribute select kept, then one idle cycle
    o_read_n                  = 1'b1;
    o_write_n                 = 1'b1;
    o_low_byte_chip_select_n  = 1'b1;
    o_high_byte_chip_select_n = 1'b1;
    o_data                    = ~o_data;
    @(negedge i_sys_clk);
  endtask : cyc
endmodule : csd_host_model

// File: csd_card_space_decoder_bench.sv
// Purpose: Self-checking bench of the card space decoder
// Assumes: Host model drives strobes; bench drives card side inputs
// Notes:   Table rows first, then ready change and mid-run reset
`timescale 1ns/10ps
module csd_card_space_decoder_bench;
  typedef struct packed {
    logic a, l, h, w; logic [10:0] ad; logic [15:0] wd, ed, m;
    logic ol, oh, inv; logic [1:0] cb;
  } csd_row_t;
  logic sys_clk = 1'b0, rst_n = 1'b0, ready = 1'b1, int_req = 1'b0;
  logic cis_ld = 1'b0, low_cs_n, high_cs_n, attr_n, rd_n, wr_n;
  logic [7:0] cis_a = 8'h00, cis_d = 8'h00, opt;
  logic [10:0] addr, c_addr, cad, cfg;
  logic [15:0] hdata, o_data, c_wd, cwd, rd;
  logic [1:0] c_be, cbe;
  logic lo_oe_n, hi_oe_n, c_rd, c_wr, soft_rst, pwr_dn, inval, ol, oh, cw;
  int bad_count = 0, n_compared = 0, n_inv = 0, n_com = 0, ni, nc;
  csd_row_t r;
  csd_row_t rows [27] = '{
    '{0,0,1,1,11'h200,16'hff05,0,0,1,1,0,0},
    '{0,0,1,0,11'h200,0,16'h0005,16'h00ff,0,1,0,0},
    '{0,0,1,1,11'h201,16'h00ff,0,0,1,1,1,0},
    '{0,0,0,0,11'h200,0,16'h0005,16'h00ff,0,1,0,0},
    '{0,1,0,1,11'h200,16'h00ff,0,0,1,1,1,0},
    '{0,0,0,1,11'h200,16'hff07,0,0,1,1,0,0},
    '{0,0,1,0,11'h200,0,16'h0007,16'h00ff,0,1,0,0},
    '{0,0,1,1,11'h202,16'h00ff,0,0,1,1,0,0},
    '{0,0,1,0,11'h202,0,16'h006c,16'h00ff,0,1,0,0},
    '{0,0,1,1,11'h204,16'h0000,0,0,1,1,0,0},
    '{0,0,1,0,11'h204,0,16'h000e,16'h00ff,0,1,0,0},
    '{0,0,1,1,11'h206,16'h00ff,0,0,1,1,0,0},
    '{0,0,1,0,11'h206,0,16'h001f,16'h00ff,0,1,0,0},
    '{0,0,1,0,11'h000,0,16'h00a5,16'h00ff,0,1,0,0},
    '{0,0,0,0,11'h002,0,16'h003c,16'h00ff,0,1,0,0},
    '{0,0,1,1,11'h000,16'h00ff,0,0,1,1,1,0},
    '{0,0,1,0,11'h000,0,16'h00a5,16'h00ff,0,1,0,0},
    '{0,0,1,0,11'h201,0,0,16'h00ff,0,1,1,0},
    '{0,1,0,0,11'h200,0,0,0,1,0,1,0},
    '{0,1,1,0,11'h200,0,0,0,1,1,0,0},
    '{1,1,1,1,11'h123,16'h1111,0,0,1,1,0,0},
    '{1,0,1,0,11'h123,0,16'h00ef,16'h00ff,0,1,0,2'h1},
    '{1,1,0,0,11'h124,0,16'hbe00,16'hff00,1,0,0,2'h2},
    '{1,0,0,0,11'h124,0,16'hbeef,16'hffff,0,0,0,2'h3},
    '{1,0,1,1,11'h7ff,16'h1234,16'h0034,16'h00ff,1,1,0,2'h1},
    '{1,1,0,1,11'h001,16'h5678,16'h5600,16'hff00,1,1,0,2'h2},
    '{1,0,0,1,11'h2aa,16'h9abc,16'h9abc,16'hffff,1,1,0,2'h3}
  };
  always #4 sys_clk = ~sys_clk;
  csd_host_model u_host (
    .i_sys_clk(sys_clk), .o_low_byte_chip_select_n(low_cs_n), .o_high_byte_chip_select_n(high_cs_n),
    .o_attr_select_n(attr_n), .o_read_n(rd_n), .o_write_n(wr_n), .o_addr(addr), .o_data(hdata),
    .i_data(o_data), .i_data_lo_oe_n(lo_oe_n), .i_data_hi_oe_n(hi_oe_n));
  csd_card_space_decoder u_dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_low_byte_chip_select_n(low_cs_n),
    .i_high_byte_chip_select_n(high_cs_n), .i_attr_select_n(attr_n), .i_read_n(rd_n),
    .i_write_n(wr_n), .i_addr(addr), .i_data(hdata), .o_data(o_data), .o_data_lo_oe_n(lo_oe_n),
    .o_data_hi_oe_n(hi_oe_n), .o_common_rd(c_rd), .o_common_wr(c_wr), .o_common_addr(c_addr),
    .o_common_be(c_be), .o_common_wdata(c_wd), .i_common_rdata(16'hbeef), .i_ready(ready),
    .i_int_req(int_req), .i_cis_load(cis_ld), .i_cis_load_addr(cis_a), .i_cis_load_data(cis_d),
    .o_configuration_option(opt), .o_soft_reset(soft_rst), .o_power_down(pwr_dn),
    .o_invalid_access(inval));
  // Pulse counters and last common-side request
  always @(posedge sys_clk) begin
    if (inval === 1'b1) n_inv <= n_inv + 1;
    if ((c_rd | c_wr) === 1'b1) begin
      n_com <= n_com + 1;
      cbe   <= c_be;
      cw    <= c_wr;
      cad   <= c_addr;
      cwd   <= c_wd;
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic acc(input logic [10:0] ad, input logic w, input logic [15:0] wd);
    u_host.cyc(1'b0, 1'b0, 1'b1, w, ad, wd, rd, ol, oh);
  endtask : acc
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    cis_ld = 1'b1;
    cis_d  = 8'ha5;
    @(negedge sys_clk);
    cis_a = 8'h01;
    cis_d = 8'h3c;
    @(negedge sys_clk);
    cis_a = 8'h02;
    cis_d = 8'h02;
    @(negedge sys_clk);
    cis_ld = 1'b0;
    foreach (rows[i]) begin
      r  = rows[i];
      ni = n_inv;
      nc = n_com;
      u_host.cyc(r.a, r.l, r.h, r.w, r.ad, r.wd, rd, ol, oh);
      if (!r.w) chk(rd & r.m, r.ed & r.m);
      else chk(cwd & r.m, r.ed & r.m);
      if (r.ol !== 1'bx) chk(16'({ol, oh}), 16'({r.ol, r.oh}));
      chk(16'(n_inv - ni), 16'(r.inv));
      chk(16'(n_com - nc), 16'(r.cb != 2'h0));
      if (r.cb != 2'h0) chk(16'({cw, cbe, cad}), 16'({r.w, r.cb, r.ad}));
    end
    chk(16'({opt, pwr_dn}), 16'h000f);
    $display("test rows done");
    ready   = 1'b0;
    int_req = 1'b1;
    repeat (2) @(negedge sys_clk);
    acc(11'h204, 1'b0, 16'h0000);
    chk(rd & 16'h00ff, 16'h002c);
    acc(11'h202, 1'b0, 16'h0000);
    chk(rd & 16'h00ff, 16'h00ee);
    acc(11'h204, 1'b1, 16'h0002);
    acc(11'h204, 1'b0, 16'h0000);
    chk(rd & 16'h00ff, 16'h000c);
    acc(11'h200, 1'b1, 16'h0080);
    chk(16'({opt, soft_rst}), 16'h0101);
    $display("test ready done");
    int_req = 1'b0;
    rst_n   = 1'b0;
    @(negedge sys_clk);
    chk(16'({opt, lo_oe_n, hi_oe_n, pwr_dn}), 16'h0006);
    rst_n = 1'b1;
    acc(11'h004, 1'b0, 16'h0000);
    chk(rd & 16'h00ff, 16'h0002);
    cfg = {rd[2:0], 8'h00};
    acc(cfg | 11'h006, 1'b0, 16'h0000);
    chk(rd & 16'h00ff, 16'h0000);
    acc(cfg, 1'b0, 16'h0000);
    chk(rd & 16'h00ff, 16'h0000);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : csd_card_space_decoder_bench
